/* logic/shift_add_bit_branch_exec.sv */
`timescale 1ns/1ps
`include "exec_regs.svh"

module shift_add_bit_branch_exec
    import exec_pkg::*;
#(
    parameter int PC_W = 15
)(
    input  wire logic            CORE_CLK,
    input  wire logic            SRST,
    input  wire logic            ISSUE,
    input  wire instr_t          INSTR,
    input  wire logic [6:0]      PEEK_ADDR,
    output logic [7:0]           PEEK_DATA,
    output logic [7:0]           ACC,
    output flags_t               FLAGS,
    output logic [PC_W-1:0]      PC,
    output logic                 BUSY
);

    logic [7:0]      mem_q [0:127];
    logic [7:0]      acc_q;
    flags_t          flags_q;
    logic [PC_W-1:0] pc_q;
    state_t          state_q;
    logic [7:0]      peek_q;
    logic            take;
    logic [7:0]      fval;
    logic [7:0]      result;
    flags_t          flags_d;
    logic            tested_bit;
    logic            skip;
    logic [PC_W-1:0] branch_pc;
    logic [PC_W-1:0] pc_d;

    // ----------------------------------------------------------------
    // Issue and operand fetch
    // ----------------------------------------------------------------
    // An instruction offered during the filler cycle is discarded
    assign take = ISSUE && (state_q == ST_EXEC);
    assign fval = mem_q[INSTR.addr];

    exec_alu exec_alu_inst (
        .op         (INSTR.op),
        .acc        (acc_q),
        .fval       (fval),
        .bit_sel    (INSTR.bit_sel),
        .flags_in   (flags_q),
        .result     (result),
        .flags_out  (flags_d),
        .tested_bit (tested_bit)
    );

    // skip when the bit is zero
    // skip when the bit is one
    assign skip = take && (((INSTR.op == OP_SKIP0) && !tested_bit) ||
                           ((INSTR.op == OP_SKIP1) && tested_bit));

    assign branch_pc = pc_q + `EX_PC_STEP
                     + PC_W'({{(PC_W-9){INSTR.offset[`EX_OFS_SIGN]}}, INSTR.offset});

    // ----------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------
    // Skip steps over the discarded word so fetch resumes past it
    always_comb begin
        pc_d = pc_q;
        if (take) begin
            if (INSTR.op == OP_BRANCH) begin
                pc_d = branch_pc;
            end else if (skip) begin
                pc_d = pc_q + `EX_SKIP_STEP;
            end else begin
                pc_d = pc_q + `EX_PC_STEP;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pc_q <= `EX_PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    // skip or branch second cycle
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_q <= ST_EXEC;
        end else begin
            unique case (state_q)
                ST_EXEC: begin
                    if (skip || (take && INSTR.op == OP_BRANCH)) begin
                        state_q <= ST_NOP;
                    end
                end
                ST_NOP: begin
                    state_q <= ST_EXEC;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Accumulator, flags and data registers
    // ----------------------------------------------------------------
    // accumulator destination
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            acc_q <= `EX_ACC_RESET;
        end else if (take && !INSTR.dest &&
                     (INSTR.op == OP_ASHR || INSTR.op == OP_ADDC)) begin
            acc_q <= result;
        end
    end

    // Only shift and add reach the flags; the ALU passes the rest through
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            flags_q <= `EX_FLAGS_RESET;
        end else if (take && (INSTR.op == OP_ASHR || INSTR.op == OP_ADDC)) begin
            flags_q <= flags_d;
        end
    end

    // register destination and bit clear write-back
    // Data registers carry no reset; software initialises them
    always_ff @(posedge CORE_CLK) begin
        if (take && ((INSTR.dest && (INSTR.op == OP_ASHR || INSTR.op == OP_ADDC))
                     || INSTR.op == OP_BCLR)) begin
            mem_q[INSTR.addr] <= result;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            peek_q <= `EX_PEEK_RESET;
        end else begin
            peek_q <= mem_q[PEEK_ADDR];
        end
    end

    assign ACC       = acc_q;
    assign FLAGS     = flags_q;
    assign PC        = pc_q;
    assign BUSY      = (state_q == ST_NOP);
    assign PEEK_DATA = peek_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_shift_sign_kept: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_ASHR && !INSTR.dest |=>
        acc_q == {$past(fval[7]), $past(fval[7:1])} && flags_q.carry == $past(fval[0]))
        else $error("shift result or carry wrong");

    chk_shift_to_reg: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_ASHR && INSTR.dest |=>
        acc_q == $past(acc_q) && mem_q[$past(INSTR.addr)] == $past(result))
        else $error("shift destination wrong");

    chk_add_carry_sum: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_ADDC && !INSTR.dest |=>
        {flags_q.carry, acc_q} ==
        $past({1'b0, acc_q} + {1'b0, fval} + {8'h00, flags_q.carry}))
        else $error("add with carry wrong");

    chk_bclr_flags_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_BCLR |=>
        flags_q == $past(flags_q) && mem_q[$past(INSTR.addr)][$past(INSTR.bit_sel)] == 1'b0)
        else $error("bit clear wrong");

    chk_skip_zero_nop: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_SKIP0 && !tested_bit |=>
        BUSY ##1 !BUSY && pc_q == $past(pc_q, 2) + `EX_SKIP_STEP)
        else $error("skip on zero wrong");

    chk_skip_one_nop: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_SKIP1 |=> BUSY == $past(tested_bit))
        else $error("skip on one wrong");

    chk_branch_target: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_BRANCH && !INSTR.offset[8] |=>
        pc_q == $past(pc_q) + `EX_PC_STEP + PC_W'($past(INSTR.offset)))
        else $error("branch target wrong");

    chk_branch_two_cyc: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && INSTR.op == OP_BRANCH |=>
        BUSY && flags_q == $past(flags_q) ##1 !BUSY && flags_q == $past(flags_q, 2))
        else $error("branch timing or flags wrong");

    chk_zero_flag_set: assert property (@(posedge CORE_CLK) disable iff (SRST)
        take && (INSTR.op == OP_ADDC || INSTR.op == OP_ASHR) |=>
        flags_q.zero == ($past(result) == 8'h00))
        else $error("zero flag wrong");

endmodule : shift_add_bit_branch_exec

/* logic/exec_regs.svh */
// Notes on behaviour
// - Shift right keeps bit 7, moves bits 7..1 down, bit 0 goes to carry.
// - Destination select 0 writes the accumulator, 1 writes the data register.
// - Add-with-carry sums accumulator, register and carry; updates carry, digit carry, zero.
// - Bit clear zeroes one bit of the register, other bits and flags untouched.
// - Skip-if-zero runs next instruction on one; on zero a two-cycle no-operation.
// - Skip-if-one runs next instruction on zero; on one a two-cycle no-operation.
// - Relative branch sign-extends its 9-bit offset and loads next address plus offset.
// - Relative branch takes two cycles and leaves every flag unchanged.
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define EX_PC_RESET    15'h0000
`define EX_ACC_RESET   8'h00
`define EX_FLAGS_RESET 3'h0
`define EX_PEEK_RESET  8'h00
`define EX_PC_STEP     15'h0001
`define EX_SKIP_STEP   15'h0002

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EX_MSB         7
`define EX_NIB_MSB     3
`define EX_OFS_SIGN    8

`endif

/* logic/exec_pkg.sv */
package exec_pkg;

    // Operations this unit executes
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_ASHR   = 3'h1,   // arith_shift_right_op
        OP_ADDC   = 3'h2,   // add_with_carry_op
        OP_BCLR   = 3'h3,   // bit_clear_op
        OP_SKIP0  = 3'h4,   // skip_if_bit_zero_op
        OP_SKIP1  = 3'h5,   // skip_if_bit_one_op
        OP_BRANCH = 3'h6    // relative_branch_op
    } op_t;

    typedef enum logic [0:0] {
        ST_EXEC = 1'b0,
        ST_NOP  = 1'b1
    } state_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_t;

    typedef struct packed {
        op_t        op;
        logic [6:0] addr;
        logic [2:0] bit_sel;
        logic       dest;
        logic [8:0] offset;
    } instr_t;

endpackage : exec_pkg

/* logic/exec_alu.sv */
`timescale 1ns/1ps
`include "exec_regs.svh"

module exec_alu
    import exec_pkg::*;
(
    input  wire op_t        op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] fval,
    input  wire logic [2:0] bit_sel,
    input  wire flags_t     flags_in,
    output logic [7:0]      result,
    output flags_t          flags_out,
    output logic            tested_bit
);

    logic [8:0] sum;
    logic [4:0] nib;

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    // full sum
    assign sum = {1'b0, acc} + {1'b0, fval} + {8'h00, flags_in.carry};
    assign nib = {1'b0, acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, flags_in.carry};
    assign tested_bit = fval[bit_sel];

    // Flags not touched by an operation pass straight through
    always_comb begin
        result    = fval;
        flags_out = flags_in;
        unique case (op)
            OP_ASHR: begin
                result          = {fval[`EX_MSB], fval[7:1]};
                flags_out.carry = fval[0];
                flags_out.zero  = ({fval[`EX_MSB], fval[7:1]} == 8'h00);
            end
            OP_ADDC: begin
                result                     = sum[7:0];
                flags_out.carry            = sum[8];
                flags_out.digit_carry_flag = nib[`EX_NIB_MSB + 1];
                flags_out.zero             = (sum[7:0] == 8'h00);
            end
            OP_BCLR: begin
                result          = fval;
                result[bit_sel] = 1'b0;
            end
            default: begin
                result = fval;
            end
        endcase
    end

endmodule : exec_alu

/* testbench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    import exec_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus rows and bench state
    // ----------------------------------------------------------------
    typedef struct packed {
        op_t        op;
        logic [2:0] bit_sel;
        logic       dest;
        logic [8:0] offset;
        logic [7:0] exp_acc;
        logic [7:0] exp_peek;
        flags_t     exp_flags;
        logic       exp_busy;
    } row_t;

    logic            CORE_CLK;
    logic            SRST;
    logic            ISSUE;
    instr_t          INSTR;
    logic [6:0]      PEEK_ADDR;
    logic [7:0]      PEEK_DATA;
    logic [7:0]      ACC;
    flags_t          FLAGS;
    logic [14:0]     PC;
    logic            BUSY;
    int              miscompares;
    int              total_checks;
    logic [14:0]     pc_e;
    logic [7:0]      peek_e;
    row_t            rows [11];

    shift_add_bit_branch_exec #(.PC_W(15)) shift_add_bit_branch_exec_inst (
        .CORE_CLK  (CORE_CLK),
        .SRST      (SRST),
        .ISSUE     (ISSUE),
        .INSTR     (INSTR),
        .PEEK_ADDR (PEEK_ADDR),
        .PEEK_DATA (PEEK_DATA),
        .ACC       (ACC),
        .FLAGS     (FLAGS),
        .PC        (PC),
        .BUSY      (BUSY)
    );

    // ----------------------------------------------------------------
    // Clock and shared tasks
    // ----------------------------------------------------------------
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Called at a falling edge; ISSUE stays up so rows run back to back
    task run(input instr_t ins);
        ISSUE = 1'b1;
        INSTR = ins;
        @(negedge CORE_CLK);
    endtask : run

    task check_cleared();
        check("acc", {8'h00, ACC}, 16'h0000);
        check("flags", {13'h0000, FLAGS}, 16'h0000);
        check("pc", {1'b0, PC}, 16'h0000);
        check("busy", {15'h0000, BUSY}, 16'h0000);
        check("peek", {8'h00, PEEK_DATA}, 16'h0000);
    endtask : check_cleared

    task tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: whole run is well under a hundred cycles
    initial begin
        #20000;
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        miscompares = 0;
        total_checks = 0;
        ISSUE = 1'b0;
        INSTR = '0;
        PEEK_ADDR = 7'h05;
        SRST = 1'b1;
        rows = '{
            '{OP_ADDC,   3'h0, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0},
            '{OP_ADDC,   3'h0, 1'b1, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0},
            '{OP_ASHR,   3'h0, 1'b1, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0},
            '{OP_ASHR,   3'h0, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0},
            '{OP_SKIP0,  3'h3, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b1},
            '{OP_SKIP1,  3'h7, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0},
            '{OP_BRANCH, 3'h0, 1'b0, 9'h0FF, 8'h00, 8'h00, 3'h1, 1'b1},
            '{OP_BRANCH, 3'h0, 1'b0, 9'h100, 8'h00, 8'h00, 3'h1, 1'b1},
            '{OP_BRANCH, 3'h0, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b1},
            '{OP_NONE,   3'h0, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0},
            '{OP_BCLR,   3'h6, 1'b0, 9'h000, 8'h00, 8'h00, 3'h1, 1'b0}};
        // Twelve rising edges under reset, release on the falling edge after them
        repeat (12) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        SRST = 1'b0;
        check_cleared();
        $display("reset test done");
        pc_e = 15'h0000;
        peek_e = 8'hxx;
        // Data memory has no reset, so clearing bit by bit shows untouched bits stay unknown
        for (int k = 0; k < 8; k++) begin
            // Peek samples the register before the write of the same edge, so it lags one
            run('{OP_BCLR, 7'h05, 3'(k), 1'b0, 9'h000});
            check("peek", {8'h00, PEEK_DATA}, {8'h00, peek_e});
            peek_e[k] = 1'b0;
            pc_e = pc_e + 15'h0001;
            check("flags", {13'h0000, FLAGS}, 16'h0000);
            check("pc", {1'b0, PC}, {1'b0, pc_e});
        end
        $display("bit clear walk done");
        foreach (rows[i]) begin
            run('{rows[i].op, 7'h05, rows[i].bit_sel, rows[i].dest, rows[i].offset});
            if (rows[i].op == OP_BRANCH) begin
                pc_e = pc_e + 15'h0001 + {{6{rows[i].offset[8]}}, rows[i].offset};
            end else begin
                pc_e = pc_e + (rows[i].exp_busy ? 15'h0002 : 15'h0001);
            end
            check("acc", {8'h00, ACC}, {8'h00, rows[i].exp_acc});
            check("flags", {13'h0000, FLAGS}, {13'h0000, rows[i].exp_flags});
            check("pc", {1'b0, PC}, {1'b0, pc_e});
            check("busy", {15'h0000, BUSY}, {15'h0000, rows[i].exp_busy});
            check("peek", {8'h00, PEEK_DATA}, {8'h00, rows[i].exp_peek});
            if (rows[i].exp_busy) begin
                // Request held through the filler slot must be ignored
                @(negedge CORE_CLK);
                check("pc filler", {1'b0, PC}, {1'b0, pc_e});
                check("busy end", {15'h0000, BUSY}, 16'h0000);
            end
        end
        $display("table test done");
        // Reset landing in the middle of a two-cycle branch
        run('{OP_BRANCH, 7'h05, 3'h0, 1'b0, 9'h010});
        check("busy", {15'h0000, BUSY}, 16'h0001);
        ISSUE = 1'b0;
        SRST = 1'b1;
        @(negedge CORE_CLK);
        SRST = 1'b0;
        check_cleared();
        $display("mid-run reset test done");
        tally_and_finish();
    end

endmodule : tb_top
